// ---- inc/utc_pkg.sv ----
// constants, offsets and field layout of the transceiver control register bank
package utc_pkg;
    // byte offsets on the register bus
    localparam logic [11:0] USB_CTRL_OFS      = 12'h100;
    localparam logic [11:0] PULL_OBSERVE_OFS  = 12'h104;
    localparam logic [11:0] OTG_CONTROL_OFS   = 12'h108;
    localparam logic [11:0] TRC0_OFS          = 12'h10C;
    localparam logic [11:0] CLKREC_STATUS_OFS = 12'h15C;
    localparam logic [11:0] IRQ_STATUS_OFS    = 12'h180;
    localparam logic [11:0] IRQ_MASK_OFS      = 12'h184;
    localparam int          ADR_W             = 12;

    // field positions
    localparam int SUSPEND_BIT     = 7;
    localparam int PULLDOWN_EN_BIT = 6;
    localparam int OBS_DP_PU_BIT   = 7;
    localparam int OBS_DP_PD_BIT   = 6;
    localparam int OBS_DM_PD_BIT   = 4;
    localparam int PLAIN_PU_BIT    = 4;
    localparam int SOFT_RST_BIT    = 7;
    localparam int TRC0_RSVD6_BIT  = 6;
    localparam int WAKE_EN_BIT     = 5;
    localparam int CLKREC_INT_BIT  = 2;
    localparam int SYNC_IRQ_DETECTED_BIT    = 1;
    localparam int RESUME_INT_BIT  = 0;
    localparam int EV_W            = 3;

    // reset values
    localparam logic [7:0]      USB_CTRL_RST    = 8'h00;
    localparam logic [7:0]      OTG_CONTROL_RST = 8'h00;
    localparam logic [7:0]      TRC0_RST        = 8'h00;
    localparam logic [EV_W-1:0] IRQ_STATUS_RST  = 3'h0;
    localparam logic [EV_W-1:0] IRQ_MASK_RST    = 3'h0;
    localparam logic [7:0]      CLKREC_CLR_CODE = 8'hFF;

    // module soft reset length in module clocks
    localparam logic [1:0] SOFT_RST_CYCLES = 2'h2;

    // number of pad-side signals passing the synchroniser
    localparam int SYNC_W = 5;
    localparam int SY_DP  = 0;
    localparam int SY_DM  = 1;
    localparam int SY_PU  = 2;
    localparam int SY_DPD = 3;
    localparam int SY_DMD = 4;
endpackage

// ---- inc/utc_sync_if.sv ----
// bundle between the bank and its pad synchroniser
interface utc_sync_if;
    import utc_pkg::*;
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] synced;
    modport src (output raw, input synced);
    modport dst (input raw, output synced);
endinterface

// ---- src/utc_sync.sv ----
// two-stage synchroniser for pad levels and pull feedback
module utc_sync
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    utc_sync_if.dst   sy
);
    import utc_pkg::*;

    logic [SYNC_W-1:0] stage1_reg;
    logic [SYNC_W-1:0] stage2_reg;

    // first stage feeds only the second one, never any logic
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end
        else
        begin
            stage1_reg <= sy.raw;
            stage2_reg <= stage1_reg;
        end
    end

    assign sy.synced = stage2_reg;
endmodule

// ---- src/utc_bank.sv ----
// transceiver control and pull observe register bank with wishbone slave
// Function
// - observe bit 7 shows whether the D+ pull-up is on.
// - observe bit 6 shows whether the D+ pull-down is on.
// - observe bit 4 shows whether the D- pull-down is on.
// - reserved read-only bits of observe, otg control and transceiver control read zero and ignore writes; the code keeps transceiver control bit 6 as written.
// - in non-otg device mode the D+ pull-up follows bit 4 of otg control.
// - writing one to transceiver control bit 7 resets the whole module, then the bit clears and reads zero.
// - with bit 5 set in device mode, resume signalling raises an asynchronous wakeup.
// - the resume detector sees the K state from the synchronised D+ and D- levels; enable it only in suspend.
// - transceiver control bit 2 sets on any unmasked clock recovery condition.
// - that combined flag clears only when 0xFF is written to the clock recovery status register.
// - the only unmasked clock recovery condition is a trim overflow of the internal oscillator.
// - transceiver control bit 1 tells whether a synchronous interrupt was detected.
// - transceiver control bit 0 tells whether the resume detector raised an interrupt.
// - suspend bit puts the transceiver in suspend and the pull-down enable bit turns on weak pull-downs.
//
// Design decision made here: register access over Wishbone.
module utc_bank
(
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [utc_pkg::ADR_W-1:0]  wb_adr_i,
    input  wire logic [31:0]                wb_dat_i,
    input  wire logic [3:0]                 wb_sel_i,
    output logic      [31:0]                wb_dat_o,
    output logic                            wb_ack_o,
    input  wire logic                       device_mode_i,
    input  wire logic                       non_otg_i,
    input  wire logic                       dp_pin_i,
    input  wire logic                       dm_pin_i,
    input  wire logic                       sync_irq_i,
    input  wire logic                       trim_overflow_i,
    output logic                            dplus_pullup_o,
    output logic                            dplus_pulldown_o,
    output logic                            dminus_pulldown_o,
    output logic                            transceiver_suspend_o,
    output logic                            module_soft_reset_o,
    output logic                            async_wakeup_o,
    output logic                            irq_o
);
    import utc_pkg::*;

    logic [7:0]      usb_ctrl_reg;
    logic [7:0]      otg_control_reg;
    logic            plain_pu_bit;
    logic            trc0_rsvd6_reg;
    logic            async_wakeup_enable;
    logic            clkrec_flag_reg;
    logic            sync_irq_detected;
    logic            resume_flag_reg;
    logic [EV_W-1:0] irq_status_reg;
    logic [EV_W-1:0] irq_mask_reg;
    logic [1:0]      soft_cnt_reg;
    logic [1:0]      soft_cnt_next;
    logic            blk_rst;
    logic            bus_req;
    logic            wr_commit;
    logic            k_state;
    logic            resume_event;
    logic [EV_W-1:0] events;
    logic [31:0]     rdata;

    utc_sync_if sy ();

    // pads and our own pull outputs go through two flops before anyone looks;
    // one process owns the whole vector so no bit ever has a second writer
    always_comb
    begin
        sy.raw          = '0;
        sy.raw[SY_DP]   = dp_pin_i;
        sy.raw[SY_DM]   = dm_pin_i;
        sy.raw[SY_PU]   = dplus_pullup_o;
        sy.raw[SY_DPD]  = dplus_pulldown_o;
        sy.raw[SY_DMD]  = dminus_pulldown_o;
    end

    utc_sync u_sync
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sy    (sy)
    );

    // byte-lane-0 write strobe to one register offset
    function automatic logic wr_hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] ofs,
                                    input logic commit, input logic [3:0] sel);
        return commit && (adr == ofs) && sel[0];
    endfunction

    // request is open; ack comes one cycle later and write lands on the ack edge
    assign bus_req   = wb_cyc_i && wb_stb_i;
    assign wr_commit = bus_req && wb_we_i && wb_ack_o;
    assign blk_rst   = rst_i || module_soft_reset_o;

    assign plain_pu_bit = otg_control_reg[PLAIN_PU_BIT];

    // full-speed K state: D+ low and D- high on the synchronised pins
    assign k_state      = !sy.synced[SY_DP] && sy.synced[SY_DM];
    // wakeup only in device mode with the enable set
    assign resume_event = async_wakeup_enable && device_mode_i && k_state;
    assign events       = {trim_overflow_i, sync_irq_i, resume_event};

    // bus ack: single pulse, dropped the cycle after it was given
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= bus_req && !wb_ack_o;
    end

    // soft reset counter; kept outside blk_rst so it cannot cut itself short
    always_comb
    begin
        soft_cnt_next = soft_cnt_reg;
        if (soft_cnt_reg != 2'h0)
            soft_cnt_next = soft_cnt_reg - 2'h1;
        else if (wr_hit(wb_adr_i, TRC0_OFS, wr_commit, wb_sel_i) && wb_dat_i[SOFT_RST_BIT])
            soft_cnt_next = SOFT_RST_CYCLES;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            soft_cnt_reg        <= 2'h0;
            module_soft_reset_o <= 1'b0;
        end
        else
        begin
            soft_cnt_reg        <= soft_cnt_next;
            module_soft_reset_o <= soft_cnt_next != 2'h0;
        end
    end

    // usb control: suspend and weak pull-down enable
    always_ff @(posedge clk_i)
    begin
        if (blk_rst)
            usb_ctrl_reg <= USB_CTRL_RST;
        else if (wr_hit(wb_adr_i, USB_CTRL_OFS, wr_commit, wb_sel_i))
            usb_ctrl_reg <= {wb_dat_i[SUSPEND_BIT], wb_dat_i[PULLDOWN_EN_BIT], 6'h00};
    end

    // otg control: only the plain-device pull-up bit is stored
    always_ff @(posedge clk_i)
    begin
        if (blk_rst)
            otg_control_reg <= OTG_CONTROL_RST;
        else if (wr_hit(wb_adr_i, OTG_CONTROL_OFS, wr_commit, wb_sel_i))
            otg_control_reg <= {3'h0, wb_dat_i[PLAIN_PU_BIT], 4'h0};
    end

    // transceiver control writable bits; bit 6 is kept as written for readback
    always_ff @(posedge clk_i)
    begin
        if (blk_rst)
        begin
            trc0_rsvd6_reg      <= TRC0_RST[TRC0_RSVD6_BIT];
            async_wakeup_enable <= TRC0_RST[WAKE_EN_BIT];
        end
        else if (wr_hit(wb_adr_i, TRC0_OFS, wr_commit, wb_sel_i))
        begin
            trc0_rsvd6_reg      <= wb_dat_i[TRC0_RSVD6_BIT];
            async_wakeup_enable <= wb_dat_i[WAKE_EN_BIT];
        end
    end

    // combined clock recovery flag: trim overflow is the one condition, set wins over the 0xFF clear
    always_ff @(posedge clk_i)
    begin
        if (blk_rst)
            clkrec_flag_reg <= TRC0_RST[CLKREC_INT_BIT];
        else if (trim_overflow_i)
            clkrec_flag_reg <= 1'b1;
        else if (wr_hit(wb_adr_i, CLKREC_STATUS_OFS, wr_commit, wb_sel_i) && wb_dat_i[7:0] == CLKREC_CLR_CODE)
            clkrec_flag_reg <= 1'b0;
    end

    // synchronous interrupt seen; software clears it with a one, a new event wins
    always_ff @(posedge clk_i)
    begin
        if (blk_rst)
            sync_irq_detected <= TRC0_RST[SYNC_IRQ_DETECTED_BIT];
        else if (sync_irq_i)
            sync_irq_detected <= 1'b1;
        else if (wr_hit(wb_adr_i, TRC0_OFS, wr_commit, wb_sel_i) && wb_dat_i[SYNC_IRQ_DETECTED_BIT])
            sync_irq_detected <= 1'b0;
    end

    // resume interrupt flag doubles as the wakeup level so it stays until software acts
    always_ff @(posedge clk_i)
    begin
        if (blk_rst)
            resume_flag_reg <= TRC0_RST[RESUME_INT_BIT];
        else if (resume_event)
            resume_flag_reg <= 1'b1;
        else if (wr_hit(wb_adr_i, TRC0_OFS, wr_commit, wb_sel_i) && wb_dat_i[RESUME_INT_BIT])
            resume_flag_reg <= 1'b0;
    end

    assign async_wakeup_o = resume_flag_reg;

    // sticky interrupt status, write one to clear, set beats clear
    always_ff @(posedge clk_i)
    begin
        if (blk_rst)
            irq_status_reg <= IRQ_STATUS_RST;
        else if (wr_hit(wb_adr_i, IRQ_STATUS_OFS, wr_commit, wb_sel_i))
            irq_status_reg <= (irq_status_reg & ~wb_dat_i[EV_W-1:0]) | events;
        else
            irq_status_reg <= irq_status_reg | events;
    end

    // interrupt mask, same layout as status
    always_ff @(posedge clk_i)
    begin
        if (blk_rst)
            irq_mask_reg <= IRQ_MASK_RST;
        else if (wr_hit(wb_adr_i, IRQ_MASK_OFS, wr_commit, wb_sel_i))
            irq_mask_reg <= wb_dat_i[EV_W-1:0];
    end

    // level interrupt; one cycle behind status to keep the output on a flop
    always_ff @(posedge clk_i)
    begin
        if (blk_rst)
            irq_o <= 1'b0;
        else
            irq_o <= |(irq_status_reg & irq_mask_reg);
    end

    // transceiver drive: pull-up only in plain device mode with otg control bit 4 set, driven low otherwise
    always_ff @(posedge clk_i)
    begin
        if (blk_rst)
        begin
            dplus_pullup_o        <= 1'b0;
            dplus_pulldown_o      <= 1'b0;
            dminus_pulldown_o     <= 1'b0;
            transceiver_suspend_o <= 1'b0;
        end
        else
        begin
            dplus_pullup_o        <= non_otg_i && device_mode_i && plain_pu_bit;
            dplus_pulldown_o      <= usb_ctrl_reg[PULLDOWN_EN_BIT];
            dminus_pulldown_o     <= usb_ctrl_reg[PULLDOWN_EN_BIT];
            transceiver_suspend_o <= usb_ctrl_reg[SUSPEND_BIT];
        end
    end

    // read mux; unmapped offsets answer zero, reserved bits stay zero except transceiver control bit 6, which reads as written
    always_comb
    begin
        rdata = 32'h0000_0000;
        case (wb_adr_i)
            USB_CTRL_OFS:
                rdata[7:0] = usb_ctrl_reg;
            PULL_OBSERVE_OFS:
            begin
                rdata[OBS_DP_PU_BIT] = sy.synced[SY_PU];
                rdata[OBS_DP_PD_BIT] = sy.synced[SY_DPD];
                rdata[OBS_DM_PD_BIT] = sy.synced[SY_DMD];
            end
            OTG_CONTROL_OFS:
                rdata[7:0] = otg_control_reg;
            TRC0_OFS:
            begin
                rdata[TRC0_RSVD6_BIT] = trc0_rsvd6_reg;
                rdata[WAKE_EN_BIT]    = async_wakeup_enable;
                rdata[CLKREC_INT_BIT] = clkrec_flag_reg;
                rdata[SYNC_IRQ_DETECTED_BIT]   = sync_irq_detected;
                rdata[RESUME_INT_BIT] = resume_flag_reg;
            end
            IRQ_STATUS_OFS:
                rdata[EV_W-1:0] = irq_status_reg;
            IRQ_MASK_OFS:
                rdata[EV_W-1:0] = irq_mask_reg;
            default:
                rdata = 32'h0000_0000;
        endcase
    end

    // read data captured on the edge that raises ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (bus_req && !wb_ack_o)
            wb_dat_o <= rdata;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (blk_rst);

    sequence s_soft_start;
        $rose(module_soft_reset_o);
    endsequence

    sequence s_soft_body;
        module_soft_reset_o [*2] ##1 !module_soft_reset_o;
    endsequence

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (disable iff (rst_i) bus_req && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked in one cycle");
    // observe reads trail the pull outputs by three cycles: two sync flops plus the read capture
    a_obs_pullup: assert property (wb_ack_o && $past(wb_adr_i) == PULL_OBSERVE_OFS
                                   |-> wb_dat_o[OBS_DP_PU_BIT] == $past(dplus_pullup_o, 3))
        else $error("observe pull-up bit lags wrongly");
    a_obs_dp_pd: assert property (wb_ack_o && $past(wb_adr_i) == PULL_OBSERVE_OFS
                                  |-> wb_dat_o[OBS_DP_PD_BIT] == $past(dplus_pulldown_o, 3))
        else $error("observe D+ pull-down bit lags wrongly");
    a_obs_dm_pd: assert property (wb_ack_o && $past(wb_adr_i) == PULL_OBSERVE_OFS
                                  |-> wb_dat_o[OBS_DM_PD_BIT] == $past(dminus_pulldown_o, 3))
        else $error("observe D- pull-down bit lags wrongly");
    a_rsvd_zero: assert property (wb_ack_o && $past(wb_adr_i) == TRC0_OFS |-> wb_dat_o[7] == 1'b0 && wb_dat_o[4:3] == 2'h0)
        else $error("reserved transceiver bits read nonzero");
    a_plain_pullup: assert property (non_otg_i && device_mode_i && plain_pu_bit |=> dplus_pullup_o)
        else $error("plain device pull-up not driven");
    a_soft_len: assert property (disable iff (rst_i) s_soft_start |-> s_soft_body)
        else $error("soft reset not two cycles long");
    a_clkrec_keep: assert property (clkrec_flag_reg && !(wr_hit(wb_adr_i, CLKREC_STATUS_OFS, wr_commit, wb_sel_i)
                                    && wb_dat_i[7:0] == CLKREC_CLR_CODE) |=> clkrec_flag_reg)
        else $error("clock recovery flag dropped without clear code");
    a_resume_set: assert property (resume_event |=> resume_flag_reg && async_wakeup_o)
        else $error("resume event did not raise flag");
    a_sync_irq_detected: assert property (sync_irq_i |=> sync_irq_detected)
        else $error("synchronous interrupt not recorded");
    a_suspend_drv: assert property (usb_ctrl_reg[SUSPEND_BIT] [*2] |-> transceiver_suspend_o)
        else $error("suspend not driven");

    // flag, interrupt, reserved readback, pad drive and wakeup gating checks
    a_clkrec_set: assert property (trim_overflow_i |=> clkrec_flag_reg)
        else $error("trim overflow did not raise clock recovery flag");
    a_irq_level: assert property (|(irq_status_reg & irq_mask_reg) |=> irq_o)
        else $error("unmasked status did not raise interrupt");
    a_rsvd_obs: assert property (wb_ack_o && $past(wb_adr_i) == PULL_OBSERVE_OFS |-> (wb_dat_o[7:0] & 8'h2F) == 8'h00)
        else $error("reserved observe bits read nonzero");
    a_rsvd_otg: assert property (wb_ack_o && $past(wb_adr_i) == OTG_CONTROL_OFS |-> (wb_dat_o[7:0] & 8'hEF) == 8'h00)
        else $error("reserved otg control bits read nonzero");
    a_pulldown_drv: assert property (usb_ctrl_reg[PULLDOWN_EN_BIT] [*2] |-> dplus_pulldown_o && dminus_pulldown_o)
        else $error("weak pull-downs not driven");
    a_wake_gate: assert property (!resume_flag_reg && !(async_wakeup_enable && device_mode_i) |=> !resume_flag_reg)
        else $error("resume flag rose without enable in device mode");
endmodule

// ---- tb/utc_usb_bus_model.sv ----
// bus-side partner model: drives the raw D+ and D- levels seen by the bank
module utc_usb_bus_model
(
    input  wire logic clk_i,
    input  wire logic resume_i,
    input  wire logic pullup_i,
    output logic      dp_o,
    output logic      dm_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // resume drives a K state; otherwise J when the pull-up holds D+ high, SE0 when detached
    always @(posedge clk_i)
    begin
        if (resume_i)
        begin
            dp_o <= 1'h0;
            dm_o <= 1'h1;
        end
        else
        begin
            dp_o <= pullup_i;
            dm_o <= 1'h0;
        end
    end
endmodule

// ---- tb/utc_bank_tb_top.sv ----
// self-checking bench for the transceiver control register bank
module utc_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import utc_pkg::*;

    logic             clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, device_mode_i, non_otg_i;
    logic             sync_irq_i, trim_overflow_i, dp_pin_i, dm_pin_i, dplus_pullup_o, dplus_pulldown_o;
    logic             dminus_pulldown_o, transceiver_suspend_o, module_soft_reset_o, async_wakeup_o, irq_o;
    logic             resume_req;
    logic [ADR_W-1:0] wb_adr_i;
    logic [31:0]      wb_dat_i, wb_dat_o, seed;
    logic [3:0]       wb_sel_i;
    logic [7:0]       r;
    logic [31:0]      exp_q[$];
    int               fail_count, samples_checked, soft_rst_cycles;

    utc_bank dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .device_mode_i(device_mode_i), .non_otg_i(non_otg_i), .dp_pin_i(dp_pin_i), .dm_pin_i(dm_pin_i),
        .sync_irq_i(sync_irq_i), .trim_overflow_i(trim_overflow_i), .dplus_pullup_o(dplus_pullup_o),
        .dplus_pulldown_o(dplus_pulldown_o), .dminus_pulldown_o(dminus_pulldown_o),
        .transceiver_suspend_o(transceiver_suspend_o), .module_soft_reset_o(module_soft_reset_o),
        .async_wakeup_o(async_wakeup_o), .irq_o(irq_o));

    utc_usb_bus_model bus (.clk_i(clk_i), .resume_i(resume_req), .pullup_i(dplus_pullup_o), .dp_o(dp_pin_i),
        .dm_o(dm_pin_i));

    // free-running 125 MHz clock
    initial
    begin
        clk_i = 1'h0;
        forever #4 clk_i = ~clk_i;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bit_chk(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // one classic cycle; a read notes its expected byte for the monitor
    task automatic wb(input logic we, input logic [ADR_W-1:0] adr, input logic [7:0] d, input logic [7:0] exp);
        int n;
        n = 0;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h0, d};
        wb_sel_i <= 4'hF;
        if (!we)
            exp_q.push_back({24'h0, exp});
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'h1 && n < 40);
        if (wb_ack_o !== 1'h1)
        begin
            fail_count++;
            close_out();
        end
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i  <= 1'h0;
        @(posedge clk_i);
    endtask

    // monitor: each read answer takes the oldest note off the queue
    always @(posedge clk_i)
    begin
        if (wb_ack_o === 1'h1 && wb_we_i === 1'h0 && exp_q.size() > 0)
            check(wb_dat_o, exp_q.pop_front());
        if (module_soft_reset_o === 1'h1)
            soft_rst_cycles++;
    end

    // main sequence
    initial
    begin
        {rst_i, device_mode_i, non_otg_i} = 3'h7;
        {wb_cyc_i, wb_stb_i, wb_we_i, sync_irq_i, trim_overflow_i, resume_req} = 6'h0;
        wb_adr_i = 12'h0;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'h0;
        seed = 32'hED28;
        {fail_count, samples_checked, soft_rst_cycles} = {32'h0, 32'h0, 32'h0};
        tick(3);
        rst_i <= 1'h0;
        @(posedge clk_i);
        wb(1'h0, USB_CTRL_OFS, 8'h0, USB_CTRL_RST);
        wb(1'h0, PULL_OBSERVE_OFS, 8'h0, 8'h00);
        wb(1'h0, OTG_CONTROL_OFS, 8'h0, OTG_CONTROL_RST);
        wb(1'h0, TRC0_OFS, 8'h0, TRC0_RST);
        wb(1'h0, 12'h110, 8'h0, 8'h00);
        wb(1'h1, OTG_CONTROL_OFS, 8'hFF, 8'h0);
        wb(1'h0, OTG_CONTROL_OFS, 8'h0, 8'h10);
        for (int i = 0; i < 4; i++)
        begin
            non_otg_i     <= i[0];
            device_mode_i <= i[1];
            tick(2);
            bit_chk(dplus_pullup_o, i == 3);
        end
        tick(3);
        wb(1'h0, PULL_OBSERVE_OFS, 8'h0, 8'h80);
        wb(1'h1, USB_CTRL_OFS, 8'hFF, 8'h0);
        tick(2);
        bit_chk(transceiver_suspend_o & dplus_pulldown_o & dminus_pulldown_o, 1'h1);
        tick(2);
        wb(1'h0, PULL_OBSERVE_OFS, 8'h0, 8'hD0);
        // random bytes against the usb control and otg control writable fields
        for (int i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            r = seed[7:0];
            wb(1'h1, USB_CTRL_OFS, r, 8'h0);
            wb(1'h0, USB_CTRL_OFS, 8'h0, r & 8'hC0);
            wb(1'h1, OTG_CONTROL_OFS, r, 8'h0);
            wb(1'h0, OTG_CONTROL_OFS, 8'h0, r & 8'h10);
        end
        wb(1'h1, OTG_CONTROL_OFS, 8'h10, 8'h0);
        wb(1'h1, USB_CTRL_OFS, 8'h80, 8'h0);
        wb(1'h1, TRC0_OFS, 8'h78, 8'h0);
        wb(1'h0, TRC0_OFS, 8'h0, 8'h60);
        wb(1'h1, IRQ_MASK_OFS, 8'h07, 8'h0);
        resume_req <= 1'h1;
        tick(8);
        bit_chk(async_wakeup_o & irq_o, 1'h1);
        resume_req <= 1'h0;
        tick(3);
        wb(1'h0, TRC0_OFS, 8'h0, 8'h61);
        wb(1'h1, TRC0_OFS, 8'h41, 8'h0);
        wb(1'h0, TRC0_OFS, 8'h0, 8'h40);
        wb(1'h1, IRQ_STATUS_OFS, 8'h07, 8'h0);
        tick(2);
        bit_chk(irq_o, 1'h0);
        // wakeup enabled outside device mode: K must not raise the flag
        device_mode_i <= 1'h0;
        wb(1'h1, TRC0_OFS, 8'h60, 8'h0);
        resume_req <= 1'h1;
        tick(8);
        bit_chk(async_wakeup_o, 1'h0);
        wb(1'h1, TRC0_OFS, 8'h40, 8'h0);
        device_mode_i <= 1'h1;
        // wakeup disabled: K must not raise the flag
        resume_req <= 1'h1;
        tick(8);
        bit_chk(async_wakeup_o, 1'h0);
        resume_req <= 1'h0;
        wb(1'h1, IRQ_MASK_OFS, 8'h00, 8'h0);
        sync_irq_i <= 1'h1;
        @(posedge clk_i);
        sync_irq_i <= 1'h0;
        tick(3);
        bit_chk(irq_o, 1'h0);
        wb(1'h0, TRC0_OFS, 8'h0, 8'h42);
        wb(1'h1, IRQ_MASK_OFS, 8'h07, 8'h0);
        tick(2);
        bit_chk(irq_o, 1'h1);
        wb(1'h1, TRC0_OFS, 8'h42, 8'h0);
        wb(1'h1, IRQ_STATUS_OFS, 8'h07, 8'h0);
        wb(1'h0, TRC0_OFS, 8'h0, 8'h40);
        trim_overflow_i <= 1'h1;
        @(posedge clk_i);
        trim_overflow_i <= 1'h0;
        tick(3);
        wb(1'h0, TRC0_OFS, 8'h0, 8'h44);
        wb(1'h1, TRC0_OFS, 8'h44, 8'h0);
        wb(1'h1, CLKREC_STATUS_OFS, 8'hFE, 8'h0);
        wb(1'h0, TRC0_OFS, 8'h0, 8'h44);
        wb(1'h1, CLKREC_STATUS_OFS, CLKREC_CLR_CODE, 8'h0);
        wb(1'h0, TRC0_OFS, 8'h0, 8'h40);
        // module soft reset
        wb(1'h1, TRC0_OFS, 8'hC0, 8'h0);
        tick(3);
        check(32'(soft_rst_cycles), 32'h2);
        wb(1'h0, TRC0_OFS, 8'h0, 8'h00);
        wb(1'h0, OTG_CONTROL_OFS, 8'h0, 8'h00);
        wb(1'h0, USB_CTRL_OFS, 8'h0, 8'h00);
        tick(2);
        bit_chk(dplus_pullup_o | irq_o, 1'h0);
        check(32'(exp_q.size()), 32'h0);
        close_out();
    end
endmodule
